// ==== inc/asp_pkg.sv ====
/*
 * Constants, timing figures and state type for the asynchronous
 * static memory word port controller.
 * Assumes a single 125 MHz clock and a 16-bit, 256K-word memory.
 */
package asp_pkg;

    // ------------------------------------------------------------
    // Clock and widths
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int ADDR_W_DEF    = 18;
    localparam int DATA_W_DEF    = 16;
    localparam int TMR_W         = 4;

    // ------------------------------------------------------------
    // Memory timing in ns, slow grade so both grades are covered
    // ------------------------------------------------------------
    localparam int ADDRESS_ACCESS_TIME_NS   = 55;
    localparam int GATE_ACCESS_TIME_NS      = 25;
    localparam int READ_CYCLE_NS            = 55;
    localparam int GATE_TO_FLOAT_NS         = 18;
    localparam int STROBE_WIDTH_NS          = 40;
    localparam int ADDRESS_TO_WRITE_END_NS  = 40;
    localparam int BYTE_LANE_TO_WRITE_END_NS = 45;
    localparam int WRITE_DATA_SETUP_NS      = 25;
    localparam int STROBE_TO_FLOAT_NS       = 20;

    function automatic int asp_max(input int a, input int b);
        return (a > b) ? a : b;
    endfunction : asp_max

    // Least times round up to whole cycles
    function automatic int asp_cyc_up(input int ns);
        return asp_max(1, (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    endfunction : asp_cyc_up

    localparam int RD_ACCESS_NS = asp_max(asp_max(ADDRESS_ACCESS_TIME_NS, GATE_ACCESS_TIME_NS), READ_CYCLE_NS);
    localparam int WR_PULSE_NS  = asp_max(asp_max(STROBE_WIDTH_NS, ADDRESS_TO_WRITE_END_NS),
                                          asp_max(BYTE_LANE_TO_WRITE_END_NS,
                                                  WRITE_DATA_SETUP_NS + STROBE_TO_FLOAT_NS));

    localparam int RD_ACCESS_CYC = asp_cyc_up(RD_ACCESS_NS);
    localparam int WR_PULSE_CYC  = asp_cyc_up(WR_PULSE_NS);
    localparam int TURN_CYC      = asp_cyc_up(GATE_TO_FLOAT_NS);

    // ------------------------------------------------------------
    // Reset levels of the memory pins
    // ------------------------------------------------------------
    localparam logic SEL_LOW_IDLE  = 1'b1;
    localparam logic SEL_HIGH_IDLE = 1'b0;
    localparam logic LANE_IDLE     = 1'b1;
    localparam logic GATE_IDLE     = 1'b1;
    localparam logic STROBE_IDLE   = 1'b1;

    typedef enum logic [2:0] {
        ASP_IDLE,
        ASP_RD_ACCESS,
        ASP_TURN,
        ASP_WR_SETUP,
        ASP_WR_PULSE,
        ASP_WR_HOLD
    } asp_state_e;

endpackage : asp_pkg

// ==== inc/asp_tmr_if.sv ====
/*
 * Carrier between the controller and its phase timer.
 * Assumes both ends share one clock.
 */
`timescale 1ns/100ps
`default_nettype none

interface asp_tmr_if;
    import asp_pkg::*;
    logic             load;
    logic [TMR_W-1:0] load_val;
    logic             done;

    modport ctl (output load, output load_val, input done);
    modport tmr (input load, input load_val, output done);
endinterface : asp_tmr_if

`default_nettype wire

// ==== test/asp_ctrl_assertions.sv ====
/*
 * Pin sequencing checks for asp_ctrl.
 * Assumes binding to the top ports with one clock domain.
 */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Checker
// ----------------------------------------
module asp_ctrl_assertions
    import asp_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int DATA_W = DATA_W_DEF
) (
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              resp_valid,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic              select_low_active_n,
    input wire logic              select_high_active,
    input wire logic              upper_byte_lane_n,
    input wire logic              lower_byte_lane_n,
    input wire logic              output_gate_n,
    input wire logic              write_strobe_n,
    input wire logic [DATA_W-1:0] mem_data_out,
    input wire logic              mem_data_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    rd_strobe_high_a: assert property (
        !output_gate_n |-> write_strobe_n) else $error("strobe low in read");
    sel_pair_a: assert property (
        select_low_active_n == !select_high_active) else $error("selects disagree");
    strobe_in_sel_a: assert property (
        !write_strobe_n |-> !select_low_active_n && mem_data_oe) else $error("strobe outside select");
    strobe_width_a: assert property (
        $fell(write_strobe_n) |-> !write_strobe_n [*6] ##1 write_strobe_n) else $error("strobe width");
    data_hold_a: assert property (
        $rose(write_strobe_n) |-> mem_data_oe && $stable(mem_data_out) && $stable(mem_addr))
        else $error("data not held");
    lane_setup_a: assert property (
        $rose(write_strobe_n) |-> $past(lower_byte_lane_n, 7) == lower_byte_lane_n
            && $past(upper_byte_lane_n, 7) == upper_byte_lane_n) else $error("lane setup");
    addr_steady_a: assert property (
        !select_low_active_n && !$past(select_low_active_n) |-> $stable(mem_addr)) else $error("address moved");
    read_span_a: assert property (
        $fell(output_gate_n) |-> !output_gate_n [*7] ##1 (output_gate_n && resp_valid))
        else $error("read span");
    gate_turn_a: assert property (
        $rose(output_gate_n) |-> !mem_data_oe [*3]) else $error("turnaround short");
    no_fight_a: assert property (
        mem_data_oe |-> output_gate_n) else $error("gate low while driving");
    c_rd: cover property ($fell(output_gate_n));
    c_wr: cover property ($fell(write_strobe_n) && !lower_byte_lane_n);
    c_nop: cover property ($fell(write_strobe_n) && lower_byte_lane_n && upper_byte_lane_n);
endmodule : asp_ctrl_assertions
`default_nettype wire

// ==== test/asp_ctrl_bench.sv ====
/*
 * Self-checking bench for asp_ctrl against a memory model.
 * Assumes the checker and model files are compiled before it.
 */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Bench
// ----------------------------------------
module asp_ctrl_bench;
    import asp_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        req_valid = 1'b0;
    logic        req_write = 1'b0;
    logic [17:0] req_addr = 18'h00000;
    logic [15:0] req_wdata = 16'h0000;
    logic [1:0]  req_be = 2'h0;
    logic        req_ready, resp_valid, select_low_active_n, select_high_active;
    logic        upper_byte_lane_n, lower_byte_lane_n, output_gate_n, write_strobe_n, mem_data_oe;
    logic [17:0] mem_addr;
    logic [15:0] resp_rdata, mem_data_in, mem_data_out;
    int          viol_cnt;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          ref_mem [int];
    asp_ctrl dut (.clk, .rst, .req_valid, .req_ready, .req_write, .req_addr, .req_wdata, .req_be,
        .resp_valid, .resp_rdata, .mem_addr, .select_low_active_n, .select_high_active,
        .upper_byte_lane_n, .lower_byte_lane_n, .output_gate_n, .write_strobe_n,
        .mem_data_in, .mem_data_out, .mem_data_oe);
    asp_sram_model mem (.clk, .mem_addr, .select_low_active_n, .select_high_active,
        .upper_byte_lane_n, .lower_byte_lane_n, .output_gate_n, .write_strobe_n,
        .mem_data_out, .mem_data_in, .viol_cnt);
    initial forever #4 clk = ~clk;
    task automatic conclude();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    task automatic check(input string nm, input logic [17:0] exp, input logic [17:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick
    // One whole request; latency and read lanes against the model
    task automatic op(input logic w, input logic [17:0] a, input logic [15:0] d, input logic [1:0] be);
        int n;
        int e;
        for (n = 0; n < 20 && req_ready !== 1'b1; n++) tick();
        if (n == 20) begin
            error_cnt++;
            $display("CHECK FAILED ready expected 1 seen %b", req_ready);
            conclude();
        end
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        req_be = be;
        tick();
        req_valid = 1'b0;
        for (n = 1; n < 20; n++) begin
            tick();
            if (w ? req_ready === 1'b1 : resp_valid === 1'b1) break;
        end
        // Write adds one setup and one hold cycle around the strobe pulse
        check("latency", w ? WR_PULSE_CYC + 2 : RD_ACCESS_CYC, n);
        if (n == 20) conclude();
        e = ref_mem.exists(int'(a)) ? ref_mem[int'(a)] : 0;
        for (int i = 0; i < 2; i++) begin
            if (w && be[i]) e = (e & ~(8'hff << 8 * i)) | (d & (8'hff << 8 * i));
            if (!w && (be == 2'h0 || be[i])) check("rdata", e >> 8 * i & 8'hff, resp_rdata[i * 8 +: 8]);
        end
        ref_mem[int'(a)] = e;
    endtask : op
    initial begin
        void'($urandom(63727));
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        check("ready", 1, req_ready);
        check("idle pins", 18'h3, {write_strobe_n, select_low_active_n});
        op(1'b1, 18'h3ffff, 16'hbeef, 2'h3);
        op(1'b1, 18'h00000, 16'h1234, 2'h3);
        op(1'b0, 18'h3ffff, 16'h0000, 2'h3);
        for (int b = 0; b < 4; b++) begin
            op(1'b1, 18'h00005, 16'h5a00 + b, b[1:0]);
            for (int r = 0; r < 4; r++) op(1'b0, 18'h00005, 16'h0000, r[1:0]);
        end
        for (int k = 0; k < 60; k++) op($urandom % 2, $urandom % 8, $urandom, $urandom % 4);
        check("timing violations", 0, viol_cnt);
        conclude();
    end
endmodule : asp_ctrl_bench
bind asp_ctrl asp_ctrl_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (.clk, .rst, .resp_valid,
    .mem_addr, .select_low_active_n, .select_high_active, .upper_byte_lane_n, .lower_byte_lane_n,
    .output_gate_n, .write_strobe_n, .mem_data_out, .mem_data_oe);
`default_nettype wire

// ==== test/asp_sram_model.sv ====
/*
 * Behavioural 256K x 16 static memory on the controller pins.
 * Assumes clk only to remember the last value seen on the data pins.
 */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Memory model
// ----------------------------------------
module asp_sram_model (
    input wire logic        clk,
    input wire logic [17:0] mem_addr,
    input wire logic        select_low_active_n,
    input wire logic        select_high_active,
    input wire logic        upper_byte_lane_n,
    input wire logic        lower_byte_lane_n,
    input wire logic        output_gate_n,
    input wire logic        write_strobe_n,
    input wire logic [15:0] mem_data_out,
    output logic [15:0]     mem_data_in,
    output var int          viol_cnt
);
    logic [15:0] mem [int];
    logic [15:0] last_q = 16'h0000;
    logic [15:0] word;
    logic        sel;
    logic        rd;
    logic        acc_ok;
    logic [20:0] key;
    logic [20:0] key_hold;
    logic [20:0] key_acc;
    realtime     t_data;
    realtime     t_lane;
    initial viol_cnt = 0;
    assign sel = !select_low_active_n && select_high_active;
    assign rd  = sel && !output_gate_n && write_strobe_n;
    assign key = {mem_addr, rd, upper_byte_lane_n, lower_byte_lane_n};
    // Inertial delays: each copy follows key only once it has stood that long
    assign #10 key_hold = key;
    assign #55 key_acc  = key;
    always @(*) begin
        word   = mem.exists(int'(mem_addr)) ? mem[int'(mem_addr)] : 16'h0000;
        acc_ok = rd && key_acc === key;
        // Pins keep their old value just after a change; early samples see junk
        if (key_hold === key || $isunknown(key_hold)) begin
            // Released lanes flip so a stale value never passes
            mem_data_in[7:0]  = (acc_ok && !lower_byte_lane_n) ? word[7:0] : ~last_q[7:0];
            mem_data_in[15:8] = (acc_ok && !upper_byte_lane_n) ? word[15:8] : ~last_q[15:8];
        end
    end
    always @(posedge clk) last_q <= mem_data_in;
    always @(mem_data_out) t_data = $realtime;
    always @(lower_byte_lane_n or upper_byte_lane_n) t_lane = $realtime;
    always @(posedge write_strobe_n) begin
        if ($realtime > 0 && sel && !(lower_byte_lane_n && upper_byte_lane_n)) begin
            if ($realtime - t_data < 25 || $realtime - t_lane < 45) viol_cnt++;
            if (!mem.exists(int'(mem_addr))) mem[int'(mem_addr)] = 16'h0000;
            if (!lower_byte_lane_n) mem[int'(mem_addr)][7:0] = mem_data_out[7:0];
            if (!upper_byte_lane_n) mem[int'(mem_addr)][15:8] = mem_data_out[15:8];
        end
    end
endmodule : asp_sram_model
`default_nettype wire

// ==== verilog/asp_ctrl.sv ====
/*
 * Host-side controller for an asynchronous 16-bit static memory:
 * takes word requests and sequences the memory pins in clock periods.
 * Assumes memory data inputs are synchronous to clk and that the
 * memory is the only other driver of the data pins.
 */
// Behaviour
// - Write strobe stays high throughout every read access.
// - Write occurs during overlap of strobe, select and a lane enable.
// - Write data valid 25 ns before write end, held 0 ns after.
// - Address, select and strobe width at least 35 or 40 ns.
// - Address valid at write start and unchanged until write end.
// - Lane enable low at least 35 or 45 ns before write end.
// - Strobe pulse covers data setup plus strobe-to-float time.
// - Address valid no later than select becoming active on reads.
// - Select pins always driven to definite levels.
`timescale 1ns/100ps
`default_nettype none

module asp_ctrl
    import asp_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int DATA_W = DATA_W_DEF
) (
    input  wire logic              clk,
    input  wire logic              rst,
    // User request side
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic              req_write,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    input  wire logic [1:0]        req_be,
    output logic                   resp_valid,
    output logic [DATA_W-1:0]      resp_rdata,
    // Memory pins
    output logic [ADDR_W-1:0]      mem_addr,
    output logic                   select_low_active_n,
    output logic                   select_high_active,
    output logic                   upper_byte_lane_n,
    output logic                   lower_byte_lane_n,
    output logic                   output_gate_n,
    output logic                   write_strobe_n,
    input  wire logic [DATA_W-1:0] mem_data_in,
    output logic [DATA_W-1:0]      mem_data_out,
    output logic                   mem_data_oe
);

    typedef struct packed {
        asp_state_e        st;
        logic              rdy;
        logic              rvld;
        logic [DATA_W-1:0] rdata;
        logic [ADDR_W-1:0] addr;
        logic              sel_n;
        logic              sel_h;
        logic              ub_n;
        logic              lb_n;
        logic              gate_n;
        logic              strobe_n;
        logic              doe;
        logic [DATA_W-1:0] dout;
    } asp_ctrl_s;

    asp_ctrl_s s_q;
    asp_ctrl_s s_d;

    asp_tmr_if tif ();

    asp_timer u_timer (
        .clk (clk),
        .rst (rst),
        .tif (tif)
    );

    // Read with no lane chosen still reads the whole word
    function automatic logic [1:0] asp_lanes_n(input logic wr, input logic [1:0] be);
        if (!wr && be == 2'b00) begin
            return 2'b00;
        end
        return ~be;
    endfunction : asp_lanes_n

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        logic [1:0] lanes_n;
        lanes_n      = asp_lanes_n(req_write, req_be);
        s_d          = s_q;
        s_d.rvld     = 1'b0;
        tif.load     = 1'b0;
        tif.load_val = '0;
        case (s_q.st)
            ASP_IDLE: begin
                if (req_valid && s_q.rdy) begin
                    s_d.rdy      = 1'b0;
                    s_d.addr     = req_addr;
                    // Address and select change on one edge
                    s_d.sel_n    = 1'b0;
                    s_d.sel_h    = 1'b1;
                    s_d.ub_n     = lanes_n[1];
                    s_d.lb_n     = lanes_n[0];
                    s_d.strobe_n = STROBE_IDLE;
                    if (req_write) begin
                        // Gate stays high so the memory never drives here
                        s_d.gate_n = GATE_IDLE;
                        s_d.doe    = 1'b1;
                        s_d.dout   = req_wdata;
                        s_d.st     = ASP_WR_SETUP;
                    end else begin
                        s_d.gate_n   = 1'b0;
                        s_d.st       = ASP_RD_ACCESS;
                        tif.load     = 1'b1;
                        tif.load_val = TMR_W'(RD_ACCESS_CYC - 1);
                    end
                end
            end
            ASP_RD_ACCESS: begin
                if (tif.done) begin
                    s_d.rdata    = mem_data_in;
                    s_d.rvld     = 1'b1;
                    s_d.sel_n    = SEL_LOW_IDLE;
                    s_d.sel_h    = SEL_HIGH_IDLE;
                    s_d.ub_n     = LANE_IDLE;
                    s_d.lb_n     = LANE_IDLE;
                    s_d.gate_n   = GATE_IDLE;
                    s_d.st       = ASP_TURN;
                    tif.load     = 1'b1;
                    // Let the memory float before anyone drives
                    tif.load_val = TMR_W'(TURN_CYC - 1);
                end
            end
            ASP_TURN: begin
                if (tif.done) begin
                    s_d.rdy = 1'b1;
                    s_d.st  = ASP_IDLE;
                end
            end
            ASP_WR_SETUP: begin
                // Write starts only once all enables overlap
                s_d.strobe_n = 1'b0;
                s_d.st       = ASP_WR_PULSE;
                tif.load     = 1'b1;
                tif.load_val = TMR_W'(WR_PULSE_CYC - 1);
            end
            ASP_WR_PULSE: begin
                if (tif.done) begin
                    // Strobe rise ends the write; data held through
                    s_d.strobe_n = STROBE_IDLE;
                    s_d.st       = ASP_WR_HOLD;
                end
            end
            ASP_WR_HOLD: begin
                // One period of hold, more than the 0 ns needed
                s_d.sel_n = SEL_LOW_IDLE;
                s_d.sel_h = SEL_HIGH_IDLE;
                s_d.ub_n  = LANE_IDLE;
                s_d.lb_n  = LANE_IDLE;
                s_d.doe   = 1'b0;
                s_d.rdy   = 1'b1;
                s_d.st    = ASP_IDLE;
            end
            default: begin
                s_d.st  = ASP_IDLE;
                s_d.rdy = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q.st       <= ASP_IDLE;
            s_q.rdy      <= 1'b1;
            s_q.rvld     <= 1'b0;
            s_q.rdata    <= '0;
            s_q.addr     <= '0;
            s_q.sel_n    <= SEL_LOW_IDLE;
            s_q.sel_h    <= SEL_HIGH_IDLE;
            s_q.ub_n     <= LANE_IDLE;
            s_q.lb_n     <= LANE_IDLE;
            s_q.gate_n   <= GATE_IDLE;
            s_q.strobe_n <= STROBE_IDLE;
            s_q.doe      <= 1'b0;
            s_q.dout     <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------
    assign req_ready           = s_q.rdy;
    assign resp_valid          = s_q.rvld;
    assign resp_rdata          = s_q.rdata;
    assign mem_addr            = s_q.addr;
    assign select_low_active_n = s_q.sel_n;
    assign select_high_active  = s_q.sel_h;
    assign upper_byte_lane_n   = s_q.ub_n;
    assign lower_byte_lane_n   = s_q.lb_n;
    assign output_gate_n       = s_q.gate_n;
    assign write_strobe_n      = s_q.strobe_n;
    assign mem_data_out        = s_q.dout;
    assign mem_data_oe         = s_q.doe;

endmodule : asp_ctrl

`default_nettype wire

// ==== verilog/asp_timer.sv ====
/*
 * Down counter that times the read access, turnaround and write strobe phases.
 * Assumes load is a one-cycle request from the controller.
 */
`timescale 1ns/100ps
`default_nettype none

module asp_timer
    import asp_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    asp_tmr_if.tmr    tif
);

    typedef struct packed {
        logic [TMR_W-1:0] cnt;
    } asp_tmr_s;

    asp_tmr_s s_q;
    asp_tmr_s s_d;

    // ------------------------------------------------------------
    // Count
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (tif.load) begin
            s_d.cnt = tif.load_val;
        end else if (s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - TMR_W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tif.done = (s_q.cnt == '0);

endmodule : asp_timer

`default_nettype wire
